// >>> dv/host_bus.sv
// Purpose: host side of the command port, an apb master issuing strobes
// Assumes: bus_ctrl then bus_data per byte, status polled at its own offset
// Notes:   testbench flips wide after a bus-width instruction
`timescale 1ns/10ps
`default_nettype none
module host_bus (
   // clock
   input  wire logic        pclk,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   // ****************************************************************
   // bus cycles
   // ****************************************************************
   logic        wide = 1'b1;  // eight lines until told otherwise
   logic        hung = 1'b0;
   logic [31:0] q;
   logic        err;
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
   end
   // entered just after a rising edge; request held until pready is taken
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) hung = 1'b1;
      // answer taken at the very edge that samples pready high
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;  // released data lines do not keep the last value
      @(posedge pclk);
   endtask
   task automatic put(input logic sel, input logic [7:0] b);
      apb(1'b1, char_lcd_pkg::OFS_BUS_CTRL, {30'h0, 1'b0, sel});
      if (wide) apb(1'b1, char_lcd_pkg::OFS_BUS_DATA, {24'h0, b});
      else begin
         // low lines carry junk, high nibble goes first
         apb(1'b1, char_lcd_pkg::OFS_BUS_DATA, {24'h0, b[7:4], ~b[7:4]});
         apb(1'b1, char_lcd_pkg::OFS_BUS_DATA, {24'h0, b[3:0], ~b[3:0]});
      end
   endtask
   task automatic get(input logic sel, output logic [7:0] b);
      apb(1'b1, char_lcd_pkg::OFS_BUS_CTRL, {30'h0, 1'b1, sel});
      apb(1'b0, char_lcd_pkg::OFS_BUS_DATA, 32'h0);
      b = q[7:0];
      if (!wide) begin
         b[7:4] = q[7:4];
         apb(1'b0, char_lcd_pkg::OFS_BUS_DATA, 32'h0);
         b[3:0] = q[7:4];
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      apb(1'b0, char_lcd_pkg::OFS_STATUS, 32'h0);
      while (q[7] !== 1'b0 && n < 30000) begin
         apb(1'b0, char_lcd_pkg::OFS_STATUS, 32'h0);
         n++;
      end
      if (q[7] !== 1'b0) hung = 1'b1;
      // flag low is not yet ready: half an oscillator period more
      repeat (char_lcd_pkg::HALF_OSC_CYC) @(posedge pclk);
   endtask
endmodule // host_bus
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self-checking bench for the character display command port
// Assumes: one clear only, its long busy dominates the run
// Notes:   random bytes from a fixed seed, corner cases by hand
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); n_fail++; end end
module testbench;
   // ****************************************************************
   // harness
   // ****************************************************************
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic         [11:0] paddr;
   logic         [31:0] pwdata;
   logic                pready;
   logic                pslverr;
   logic         [31:0] prdata;
   logic                internal_op_flag;
   char_lcd_pkg::mode_s mode;
   logic          [6:0] address_counter;
   logic          [7:0] b0, b1, g, r;
   int                  n_fail = 0, samples_checked = 0, seed = 17580, run = 0, busy_len = 0;
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   char_lcd_command_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .internal_op_flag(internal_op_flag),
      .mode(mode), .address_counter(address_counter));
   host_bus host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
   // length of the last busy stretch, in clocks
   always @(posedge pclk) begin
      if (internal_op_flag === 1'b1) run <= run + 1;
      else begin
         if (run != 0) busy_len <= run;
         run <= 0;
      end
   end
   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [6:0] next_ac(input logic [6:0] a, input logic two);
      if (two && a == char_lcd_pkg::ROW0_LAST) return char_lcd_pkg::ROW1_FIRST;
      if (two && a == char_lcd_pkg::ROW1_LAST) return char_lcd_pkg::HOME_ADDR;
      if (!two && a == char_lcd_pkg::ONE_LAST) return char_lcd_pkg::HOME_ADDR;
      return a + 7'h01;
   endfunction
   task automatic cmd(input logic sel, input logic [7:0] b, input int cyc);
      host_u.put(sel, b);
      host_u.apb(1'b0, char_lcd_pkg::OFS_STATUS, 32'h0);
      `CHK("busy", 1'b1, host_u.q[7]);
      host_u.wait_idle();
      `CHK("busy length", cyc, busy_len);
   endtask
   task automatic rd(input logic [7:0] e, input logic [6:0] ac);
      host_u.get(1'b1, r);
      `CHK("read data", e, r);
      `CHK("counter", ac, address_counter);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (130000) @(posedge pclk);
      n_fail++;
      close_out();
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("reset mode", char_lcd_pkg::MODE_RESET, mode);
      host_u.apb(1'b0, char_lcd_pkg::OFS_STATUS, 32'h0);
      `CHK("status", 8'h00, host_u.q[7:0]);
      host_u.apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped", 1'b1, host_u.err);
      $display("test reset done");
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      g = 8'($random(seed));
      cmd(1'b0, 8'h85, char_lcd_pkg::SHORT_OP_CYC);
      `CHK("status counter", 7'h05, host_u.q[6:0]);
      host_u.get(1'b0, r);
      `CHK("status via data", 8'h05, r);
      cmd(1'b1, b0, char_lcd_pkg::DATA_OP_CYC);
      cmd(1'b1, b1, char_lcd_pkg::DATA_OP_CYC);
      `CHK("counter after writes", 7'h07, address_counter);
      cmd(1'b0, 8'h04, char_lcd_pkg::SHORT_OP_CYC);
      `CHK("step direction", 1'b0, mode.step_direction);
      cmd(1'b0, 8'h86, char_lcd_pkg::SHORT_OP_CYC);
      rd(b1, 7'h05);
      rd(b0, 7'h04);
      cmd(1'b0, 8'h14, char_lcd_pkg::SHORT_OP_CYC);
      `CHK("cursor right", 7'h05, address_counter);
      rd(b0, 7'h04);
      cmd(1'b0, 8'h0d, char_lcd_pkg::SHORT_OP_CYC);
      `CHK("view flags", 3'b101, {mode.view_on, mode.pointer_visible, mode.pointer_flash});
      cmd(1'b0, 8'h1c, char_lcd_pkg::SHORT_OP_CYC);
      host_u.apb(1'b0, char_lcd_pkg::OFS_FLAGS, 32'h0);
      `CHK("view shift", {7'h01, 7'h04}, {host_u.q[14:8], address_counter});
      $display("test text memory done");
      cmd(1'b0, 8'h43, char_lcd_pkg::SHORT_OP_CYC);
      cmd(1'b1, g, char_lcd_pkg::DATA_OP_CYC);
      cmd(1'b0, 8'h43, char_lcd_pkg::SHORT_OP_CYC);
      rd(g, 7'h02);
      $display("test glyph memory done");
      cmd(1'b0, 8'h28, char_lcd_pkg::SHORT_OP_CYC);
      host_u.wide = 1'b0;
      `CHK("narrow bus", 3'b010, mode[2:0]);
      host_u.apb(1'b1, char_lcd_pkg::OFS_BUS_CTRL, 32'h0);
      host_u.apb(1'b1, char_lcd_pkg::OFS_BUS_DATA, 32'h0f);
      `CHK("busy after one nibble", 1'b0, internal_op_flag);
      host_u.apb(1'b1, char_lcd_pkg::OFS_BUS_DATA, 32'h1e);
      `CHK("busy after two nibbles", 1'b1, internal_op_flag);
      host_u.wait_idle();
      `CHK("clear length", char_lcd_pkg::LONG_OP_CYC, busy_len);
      `CHK("clear home", char_lcd_pkg::HOME_ADDR, address_counter);
      `CHK("clear increment", 1'b1, mode.step_direction);
      cmd(1'b0, 8'ha7, char_lcd_pkg::SHORT_OP_CYC);
      cmd(1'b1, b1, char_lcd_pkg::DATA_OP_CYC);
      `CHK("row wrap", next_ac(7'h27, 1'b1), address_counter);
      cmd(1'b0, 8'h85, char_lcd_pkg::SHORT_OP_CYC);
      rd(char_lcd_pkg::SPACE_CODE, next_ac(7'h05, 1'b1));
      `CHK("host bus hang", 1'b0, host_u.hung);
      $display("test narrow bus done");
      close_out();
   end
endmodule // testbench
`default_nettype wire

// >>> logic/char_lcd_command_port.sv
// Purpose: instruction decode, memories and address counter of a character display
// Assumes: apb master; writing bus_data performs one strobe with the sel/dir in bus_ctrl
// Notes:   clear-display fills memory one location per cycle while busy
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - data read returns a byte from the memory chosen by the last address set
// - a read with no prior address set may return a stale first byte
// - cursor shift acts like a text address set for reads, loading output data
// - after each data read the counter steps by one per step_direction
// - after a data write the counter steps by one as for reads
// - clear fills text memory with space and homes the counter, about 1.53 ms
// - return home zeroes the counter and view shift, about 1.53 ms
// - entry mode sets step_direction and whole_view_scroll, 39 us
// - display control sets view, pointer and flash flags, 39 us
// - shift instruction moves cursor or view one step, 39 us
// - function set takes bus width, rows and glyph height, 39 us
// - glyph address set loads counter and selects glyph memory, 39 us
// - text address set loads counter and selects text memory, 39 us
// - status read returns busy flag and counter, no execution time
// - data write stores into selected memory, 43 us
// - wide mode moves one byte per strobe on eight lines
// - narrow mode uses only the upper four lines
// - narrow mode sends high nibble then low nibble, reads and writes
// - narrow mode raises busy only after the second nibble
// - wide_bus_select 1 is eight bit, 0 is four bit
// - move_target 0 moves cursor, 1 shifts view; move_way 1 is right
// - text addresses wrap per row in two-line mode, 00h-4fh in one-line
// - busy flag reads 1 while an instruction executes
module char_lcd_command_port (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [31:0] prdata,
   // display state
   output logic             internal_op_flag,
   output char_lcd_pkg::mode_s mode,
   output logic       [6:0] address_counter
);
   // ****************************************************************
   // bus decode
   // ****************************************************************
   logic        acc;
   logic        wr_ctrl;
   logic        wr_data;
   logic        rd_data;
   logic        cmd_or_data_sel;
   logic        direction_sel;
   logic        nibble_phase;
   logic        glyph_sel;
   logic        read_valid;
   logic [7:0]  out_data;
   logic [7:0]  low_hold;
   logic [6:0]  view_offset;
   logic [20:0] busy_cnt;
   logic [6:0]  clear_idx;
   logic        clearing;
   logic [7:0]  text_mem  [char_lcd_pkg::TEXT_DEPTH];
   logic [7:0]  glyph_mem [char_lcd_pkg::GLYPH_DEPTH];

   // zero wait states: every access ends in its first access cycle
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign wr_ctrl = acc && pwrite && paddr == char_lcd_pkg::OFS_BUS_CTRL;
   assign wr_data = acc && pwrite && paddr == char_lcd_pkg::OFS_BUS_DATA;
   assign rd_data = acc && !pwrite && paddr == char_lcd_pkg::OFS_BUS_DATA;
   assign pslverr = acc && paddr != char_lcd_pkg::OFS_BUS_CTRL
                  && paddr != char_lcd_pkg::OFS_BUS_DATA
                  && paddr != char_lcd_pkg::OFS_STATUS
                  && paddr != char_lcd_pkg::OFS_FLAGS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_or_data_sel <= 1'b0;
         direction_sel   <= 1'b0;
      end else if (wr_ctrl) begin
         cmd_or_data_sel <= pwdata[char_lcd_pkg::CTRL_SEL_POS];
         direction_sel   <= pwdata[char_lcd_pkg::CTRL_DIR_POS];
      end
   end

   // ****************************************************************
   // strobe assembly: one strobe per bus_data access
   // ****************************************************************
   logic       strobe;
   logic       byte_done;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic [7:0] status_byte;

   assign strobe    = wr_data || rd_data;
   // narrow mode completes a byte on the second nibble only
   assign byte_done = strobe && (mode.wide_bus_select || nibble_phase);
   assign wbyte     = mode.wide_bus_select ? pwdata[7:0]
                    : {low_hold[7:4], pwdata[7:4]};
   assign status_byte = {internal_op_flag, address_counter};
   assign rbyte     = cmd_or_data_sel ? out_data : status_byte;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nibble_phase <= 1'b0;
         low_hold     <= 8'h00;
      end else if (strobe && !mode.wide_bus_select) begin
         nibble_phase <= !nibble_phase;
         if (!nibble_phase)
            low_hold <= {pwdata[7:4], 4'h0};
      end else if (mode.wide_bus_select) begin
         nibble_phase <= 1'b0;
      end
   end

   // read data: nibble phase picks high then low half on the upper lines
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         char_lcd_pkg::OFS_BUS_CTRL: prdata = {30'h0, direction_sel, cmd_or_data_sel};
         char_lcd_pkg::OFS_BUS_DATA:
            if (mode.wide_bus_select)
               prdata = {24'h0, rbyte};
            else
               prdata = {24'h0, nibble_phase ? rbyte[3:0] : rbyte[7:4], 4'h0};
         char_lcd_pkg::OFS_STATUS:   prdata = {24'h0, status_byte};
         char_lcd_pkg::OFS_FLAGS:    prdata = {17'h0, view_offset, mode};
         default:                    prdata = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // instruction decode
   // ****************************************************************
   logic is_cmd;
   logic is_dwr;
   logic is_drd;
   logic [6:0] step_addr;
   logic [6:0] next_addr;
   logic [6:0] wrap_addr;

   assign is_cmd = byte_done && !cmd_or_data_sel && !direction_sel && !internal_op_flag;
   assign is_dwr = byte_done && cmd_or_data_sel && !direction_sel && !internal_op_flag;
   assign is_drd = byte_done && cmd_or_data_sel && direction_sel;

   // on data accesses glyph addresses roll over six bits; cursor shifts always use text row wrapping
   function automatic logic [6:0] wrap(input logic [6:0] a, input logic up, input logic two,
                                       input logic glyph);
      logic [6:0] r;
      r = up ? a + 7'd1 : a - 7'd1;
      if (glyph)
         r = {1'b0, r[5:0]};
      else if (two) begin
         if (up && a == char_lcd_pkg::ROW0_LAST) r = char_lcd_pkg::ROW1_FIRST;
         else if (up && a == char_lcd_pkg::ROW1_LAST) r = char_lcd_pkg::HOME_ADDR;
         else if (!up && a == char_lcd_pkg::HOME_ADDR) r = char_lcd_pkg::ROW1_LAST;
         else if (!up && a == char_lcd_pkg::ROW1_FIRST) r = char_lcd_pkg::ROW0_LAST;
      end else begin
         if (up && a == char_lcd_pkg::ONE_LAST) r = char_lcd_pkg::HOME_ADDR;
         else if (!up && a == char_lcd_pkg::HOME_ADDR) r = char_lcd_pkg::ONE_LAST;
      end
      return r;
   endfunction

   assign step_addr = wrap(address_counter, mode.step_direction, mode.two_row_select, glyph_sel);
   assign wrap_addr = wrap(address_counter, wbyte[2], mode.two_row_select, 1'b0);

   always_comb begin
      next_addr = address_counter;
      if (is_cmd) begin
         if (wbyte[7])
            next_addr = wbyte[6:0];
         else if (wbyte[6])
            next_addr = {1'b0, wbyte[5:0]};
         else if (wbyte[7:2] == 6'b000001 && !wbyte[3])
            next_addr = address_counter;
         else if (wbyte[7:4] == 4'b0001 && !wbyte[3])
            next_addr = wrap_addr;
         else if (wbyte[7:1] == 7'b0000001 || wbyte == 8'h01)
            next_addr = char_lcd_pkg::HOME_ADDR;
      end else if (is_dwr || is_drd) begin
         next_addr = step_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         address_counter <= char_lcd_pkg::HOME_ADDR;
      else
         address_counter <= next_addr;
   end

   // mode flags and memory select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode        <= char_lcd_pkg::MODE_RESET;
         glyph_sel   <= 1'b0;
         view_offset <= 7'h00;
      end else if (is_cmd) begin
         if (wbyte[7])
            glyph_sel <= 1'b0;
         else if (wbyte[6])
            glyph_sel <= 1'b1;
         else if (wbyte[5]) begin
            mode.wide_bus_select   <= wbyte[4];
            mode.two_row_select    <= wbyte[3];
            mode.tall_glyph_select <= wbyte[2];
         end else if (wbyte[4]) begin
            if (wbyte[3]) // view shift, counter untouched
               view_offset <= wbyte[2] ? view_offset + 7'd1 : view_offset - 7'd1;
         end else if (wbyte[3]) begin
            mode.view_on         <= wbyte[2];
            mode.pointer_visible <= wbyte[1];
            mode.pointer_flash   <= wbyte[0];
         end else if (wbyte[2]) begin
            mode.step_direction    <= wbyte[1];
            mode.whole_view_scroll <= wbyte[0];
         end else if (wbyte[1]) begin
            view_offset <= 7'h00;
         end else if (wbyte[0]) begin
            view_offset         <= 7'h00;
            mode.step_direction <= 1'b1;
         end
      end else if (is_dwr && mode.whole_view_scroll && !glyph_sel) begin
         // view follows text writes; glyph accesses leave it alone
         view_offset <= mode.step_direction ? view_offset + 7'd1 : view_offset - 7'd1;
      end
   end

   // ****************************************************************
   // execution timer
   // ****************************************************************
   // a command or data-write strobe while busy is dropped, not queued (data reads still act): the host must poll first
   logic [20:0] load_cnt;

   always_comb begin
      load_cnt = 21'd0;
      if (is_dwr)
         load_cnt = 21'(char_lcd_pkg::DATA_OP_CYC);
      else if (is_cmd) begin
         if (wbyte[7:1] == 7'b0000000 || wbyte[7:1] == 7'b0000001)
            load_cnt = 21'(char_lcd_pkg::LONG_OP_CYC);
         else
            load_cnt = 21'(char_lcd_pkg::SHORT_OP_CYC);
         if (wbyte == 8'h00)
            load_cnt = 21'd0;
      end
   end

   // busy only once the full byte is in, i.e. after the second nibble
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         busy_cnt <= 21'd0;
      else if (load_cnt != 21'd0)
         busy_cnt <= load_cnt;
      else if (busy_cnt != 21'd0)
         busy_cnt <= busy_cnt - 21'd1;
   end
   assign internal_op_flag = busy_cnt != 21'd0;

   // ****************************************************************
   // memories
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clearing  <= 1'b0;
         clear_idx <= 7'h00;
      end else if (is_cmd && wbyte == 8'h01) begin
         clearing  <= 1'b1;
         clear_idx <= 7'h00;
      end else if (clearing) begin
         clearing  <= clear_idx != 7'h7f;
         clear_idx <= clear_idx + 7'd1;
      end
   end

   // memories carry no reset: contents are undefined until written
   always_ff @(posedge pclk) begin
      if (clearing)
         text_mem[clear_idx] <= char_lcd_pkg::SPACE_CODE;
      else if (is_dwr && !glyph_sel)
         text_mem[address_counter] <= wbyte;
      if (is_dwr && glyph_sel)
         glyph_mem[address_counter[5:0]] <= wbyte;
   end

   // output data register: refilled on address set, cursor shift and each read;
   // after a write it stays stale, so the next read shows the old byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_data   <= 8'h00;
         read_valid <= 1'b0;
      end else if (is_cmd && (wbyte[7] || wbyte[7:3] == 5'b00010)) begin
         out_data   <= text_mem[next_addr];
         read_valid <= 1'b1;
      end else if (is_cmd && wbyte[7:6] == 2'b01) begin
         out_data   <= glyph_mem[wbyte[5:0]];
         read_valid <= 1'b1;
      end else if (is_drd) begin
         // prefetch the next byte so back-to-back reads are correct
         out_data   <= glyph_sel ? glyph_mem[step_addr[5:0]] : text_mem[step_addr];
         read_valid <= 1'b1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // stores are compared one edge late, through $past of the write port
   busy_after_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_dwr |=> internal_op_flag) else $error("busy not raised after data write");
   step_on_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_drd && !glyph_sel && !is_cmd |=> address_counter == $past(step_addr))
      else $error("counter did not step after read");
   text_addr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7] |=> address_counter == $past(wbyte[6:0]) && !glyph_sel)
      else $error("text address set wrong");
   glyph_addr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:6] == 2'b01 |=> glyph_sel && address_counter[6] == 1'b0)
      else $error("glyph address set wrong");
   short_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:4] == 4'b0001 |=> internal_op_flag [*8])
      else $error("shift busy too short");
   home_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:1] == 7'b0000001 |=> address_counter == 7'h00 && view_offset == 7'h00)
      else $error("return home failed");
   first_nibble_a: assert property (@(posedge pclk) disable iff (!presetn)
      strobe && !mode.wide_bus_select && !nibble_phase && !internal_op_flag
      |=> !internal_op_flag) else $error("busy after first nibble");
   entry_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:2] == 6'b000001 |=> mode.step_direction == $past(wbyte[1]))
      else $error("entry mode not taken");
   status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_data && !cmd_or_data_sel && mode.wide_bus_select
      |-> prdata[7:0] == {internal_op_flag, address_counter})
      else $error("status byte wrong");
   clear_home_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte == 8'h01 |=> clearing && address_counter == char_lcd_pkg::HOME_ADDR)
      else $error("clear did not start");
   long_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte == 8'h01 |=> busy_cnt == 21'(char_lcd_pkg::LONG_OP_CYC))
      else $error("clear busy length wrong");
   space_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
      clearing |=> text_mem[$past(clear_idx)] == char_lcd_pkg::SPACE_CODE)
      else $error("clear left a location unfilled");
   text_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_dwr && !glyph_sel |=> text_mem[$past(address_counter)] == $past(wbyte))
      else $error("text byte not stored");
   glyph_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_dwr && glyph_sel |=> glyph_mem[$past(address_counter[5:0])] == $past(wbyte))
      else $error("glyph byte not stored");
   view_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:3] == 5'b00001 |=> {mode.view_on, mode.pointer_visible,
      mode.pointer_flash} == $past(wbyte[2:0])) else $error("display flags not taken");
   view_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:3] == 5'b00011 |=> address_counter == $past(address_counter))
      else $error("view shift moved the counter");
   bus_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_cmd && wbyte[7:5] == 3'b001 |=> mode.wide_bus_select == $past(wbyte[4]))
      else $error("bus width not taken");
   row_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      is_dwr && !glyph_sel && mode.two_row_select && mode.step_direction
      && address_counter == char_lcd_pkg::ROW0_LAST
      |=> address_counter == char_lcd_pkg::ROW1_FIRST) else $error("row wrap wrong");
endmodule // char_lcd_command_port
`default_nettype wire

// >>> logic/char_lcd_pkg.sv
// Purpose: shared constants and carriers for the character display command port
// Assumes: 50 MHz pclk, apb register access
// Notes:   execution times scaled from a nominal 270 kHz oscillator
`default_nettype none
package char_lcd_pkg;
   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [11:0] OFS_BUS_CTRL = 12'h000;
   localparam logic [11:0] OFS_BUS_DATA = 12'h004;
   localparam logic [11:0] OFS_STATUS   = 12'h008;
   localparam logic [11:0] OFS_FLAGS    = 12'h00c;
   // bus_ctrl field positions
   localparam int CTRL_SEL_POS = 0;
   localparam int CTRL_DIR_POS = 1;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ      = 50_000_000;
   localparam int LONG_OP_US  = 1530;
   localparam int SHORT_OP_US = 39;
   localparam int DATA_OP_US  = 43;
   localparam int OSC_HZ      = 270_000;
   localparam int LONG_OP_CYC  = LONG_OP_US * (CLK_HZ / 1_000_000);
   localparam int SHORT_OP_CYC = SHORT_OP_US * (CLK_HZ / 1_000_000);
   localparam int DATA_OP_CYC  = DATA_OP_US * (CLK_HZ / 1_000_000);
   localparam int HALF_OSC_CYC = (CLK_HZ + 2 * OSC_HZ - 1) / (2 * OSC_HZ);
   // ****************************************************************
   // memory sizes and reset values
   // ****************************************************************
   localparam int TEXT_DEPTH  = 128;
   localparam int GLYPH_DEPTH = 64;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [6:0] HOME_ADDR  = 7'h00;
   localparam logic [6:0] ROW0_LAST  = 7'h27;
   localparam logic [6:0] ROW1_FIRST = 7'h40;
   localparam logic [6:0] ROW1_LAST  = 7'h67;
   localparam logic [6:0] ONE_LAST   = 7'h4f;

   typedef struct packed {
      logic view_on;
      logic pointer_visible;
      logic pointer_flash;
      logic step_direction;
      logic whole_view_scroll;
      logic wide_bus_select;
      logic two_row_select;
      logic tall_glyph_select;
   } mode_s;

   localparam mode_s MODE_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
endpackage
`default_nettype wire
